// file: bench/pfs_feed_model.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"
module pfs_feed_model (
  input  wire logic        i_clk_sys,   // Clock
  input  wire logic        i_sys_rst,   // Reset
  input  wire logic        i_pickup,    // Pick-up drive
  input  wire logic        i_regsol,    // Roller drive
  input  wire logic [7:0]  i_speed,     // Feed speed
  input  wire logic [15:0] i_delay,     // Cycles to arrival
  input  wire logic [15:0] i_len_mm,    // Sheet length
  output logic             o_reg_sensor // Blocked by sheet
);
  logic [15:0] wait_q;
  logic [31:0] fed_q;
  // Sheet travels only while a drive is on, so a stalled pick never arrives
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !(i_pickup || i_regsol || o_reg_sensor)) begin
      wait_q <= '0;
      fed_q <= '0;
      o_reg_sensor <= 1'b0;
    end else if (!o_reg_sensor && fed_q == 0) begin
      wait_q <= wait_q + 16'h0001;
      if (wait_q == i_delay) o_reg_sensor <= 1'b1;
    end else if (o_reg_sensor && i_regsol) begin
      fed_q <= fed_q + 32'(i_speed);
      if (fed_q >= 32'(i_len_mm) * `PFS_UM_PER_MM) o_reg_sensor <= 1'b0;
    end
  end
endmodule : pfs_feed_model

// file: bench/tb.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"
module tb
  import pfs_pkg::*;
;
  logic i_clk_sys, i_sys_rst, i_print_req, i_image_start, i_err_clear, i_job_cancel;
  logic i_tray_empty_sensor, i_registration_sensor, i_transparency_sensor;
  pfs_media_t  i_media_type;
  logic [15:0] i_req_len_mm, o_meas_len_mm, sheet_len, pick_dly;
  logic [7:0]  o_main_motor_speed;
  logic o_main_motor_run, o_pickup_solenoid, o_registration_solenoid, o_busy;
  logic o_tray_empty, o_type_mismatch, o_size_error, o_misfeed, o_clean_trigger;
  int          bad_count = 0, check_count = 0, clean_cnt = 0, c0;
  logic [31:0] seed = 32'h05BE752D;
  wire  [2:0]  mon = {o_busy, o_registration_solenoid, o_pickup_solenoid};
  pfs_paper_feed #(.PICK_TMO_CYC(200), .MS_CYC(1)) pfs_paper_feed_inst (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_print_req(i_print_req),
    .i_media_type(i_media_type), .i_req_len_mm(i_req_len_mm), .i_image_start(i_image_start),
    .i_err_clear(i_err_clear), .i_job_cancel(i_job_cancel),
    .i_tray_empty_sensor(i_tray_empty_sensor), .i_registration_sensor(i_registration_sensor),
    .i_transparency_sensor(i_transparency_sensor), .o_main_motor_speed(o_main_motor_speed),
    .o_main_motor_run(o_main_motor_run), .o_pickup_solenoid(o_pickup_solenoid),
    .o_registration_solenoid(o_registration_solenoid), .o_busy(o_busy),
    .o_tray_empty(o_tray_empty), .o_type_mismatch(o_type_mismatch),
    .o_size_error(o_size_error), .o_misfeed(o_misfeed), .o_clean_trigger(o_clean_trigger),
    .o_meas_len_mm(o_meas_len_mm));
  pfs_feed_model pfs_feed_model_inst (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_pickup(o_pickup_solenoid), .i_regsol(o_registration_solenoid),
    .i_speed(o_main_motor_speed), .i_delay(pick_dly), .i_len_mm(sheet_len),
    .o_reg_sensor(i_registration_sensor));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (o_clean_trigger === 1'b1) clean_cnt <= clean_cnt + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] exp_speed(input pfs_media_t m);
    case (m)
      PFS_MEDIA_PLAIN, PFS_MEDIA_LETTERHEAD: return `PFS_SPD_FAST;
      PFS_MEDIA_FILM, PFS_MEDIA_ENVELOPE:    return `PFS_SPD_SLOW;
      default:                               return `PFS_SPD_MID;
    endcase
  endfunction : exp_speed
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_bit(input int idx, input logic val, input int bound);
    int n;
    for (n = 0; n < bound && mon[idx] !== val; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    if (n == bound) begin
      bad_count++;
      complete_run();
    end
  endtask : wait_bit
  task automatic pulse_req(input pfs_media_t m, input logic [15:0] rlen);
    @(posedge i_clk_sys);
    i_print_req <= 1'b1;
    i_media_type <= m;
    i_req_len_mm <= rlen;
    @(posedge i_clk_sys);
    i_print_req <= 1'b0;
    #1;
  endtask : pulse_req
  task automatic do_reset();
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1;
    check("idle", {o_busy, o_size_error, o_misfeed, o_pickup_solenoid}, 0);
  endtask : do_reset
  task automatic sheet(input pfs_media_t m, input logic [15:0] len, input logic [15:0] rlen,
                       input logic [15:0] dly, input logic film);
    logic mis;
    mis = film != (m == PFS_MEDIA_FILM);
    sheet_len <= len;
    pick_dly <= dly;
    i_transparency_sensor <= film;
    pulse_req(m, rlen);
    check("pickup", o_pickup_solenoid, 1'b1);
    check("speed", o_main_motor_speed, exp_speed(m));
    wait_bit(0, 1'b0, 1000);
    repeat (3) @(posedge i_clk_sys);
    #1;
    check("misfeed", o_misfeed, dly > 400);
    if (dly > 400) return;
    check("type", o_type_mismatch, mis);
    if (mis) return;
    check("hold", {o_main_motor_run, o_registration_solenoid}, 0);
    @(posedge i_clk_sys);
    i_image_start <= 1'b1;
    @(posedge i_clk_sys);
    i_image_start <= 1'b0;
    wait_bit(1, 1'b1, 4);
    check("run", o_main_motor_run, 1'b1);
    wait_bit(2, 1'b0, 20000);
    check("len", (o_meas_len_mm + 16'h0002 - len) <= 4, 1'b1);
    check("size", o_size_error, len != rlen);
  endtask : sheet
  initial begin
    {i_print_req, i_image_start, i_err_clear, i_job_cancel, i_transparency_sensor} = '0;
    i_sys_rst = 1'b1;
    i_tray_empty_sensor = 1'b0;
    i_media_type = PFS_MEDIA_PLAIN;
    i_req_len_mm = '0;
    {sheet_len, pick_dly} = '0;
    do_reset();
    i_tray_empty_sensor <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    c0 = clean_cnt;
    pulse_req(PFS_MEDIA_PLAIN, 16'h0064);
    repeat (2) @(posedge i_clk_sys);
    #1;
    check("empty", {o_tray_empty, o_pickup_solenoid}, 2'h2);
    check("clean", 16'(clean_cnt - c0), 16'h0001);
    i_tray_empty_sensor <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sheet(pfs_media_t'(i), 16'(seed[5:0] + 60), 16'(seed[5:0] + 60),
            16'(seed[13:8] + 20), i == 6);
    end
    sheet(PFS_MEDIA_THICK, 16'h0050, 16'h0050, 16'h012C, 1'b0);
    sheet(PFS_MEDIA_PLAIN, 16'h0050, 16'h0050, 16'h01F4, 1'b0);
    do_reset();
    sheet(PFS_MEDIA_PLAIN, 16'h0050, 16'h0050, 16'h001E, 1'b1);
    do_reset();
    sheet(PFS_MEDIA_FILM, 16'h0050, 16'h0050, 16'h001E, 1'b0);
    do_reset();
    c0 = clean_cnt;
    sheet(PFS_MEDIA_LABEL, 16'h0046, 16'h005A, 16'h0028, 1'b0);
    @(posedge i_clk_sys);
    #1;
    check("clean", 16'(clean_cnt - c0), 16'h0001);
    pulse_req(PFS_MEDIA_LABEL, 16'h0046);
    check("held", o_pickup_solenoid, 1'b0);
    seed = xs(seed);
    @(posedge i_clk_sys);
    i_err_clear <= seed[0];
    i_job_cancel <= !seed[0];
    @(posedge i_clk_sys);
    {i_err_clear, i_job_cancel} <= 2'h0;
    sheet(PFS_MEDIA_LABEL, 16'h0046, 16'h0046, 16'h0028, 1'b0);
    complete_run();
  end
endmodule : tb

// file: verilog/pfs_cfg.svh
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
// Feed speeds in um per ms (equal to mm per s times 1000 / 1000)
`define PFS_SPD_FAST        8'h7F
`define PFS_SPD_MID         8'h3F
`define PFS_SPD_SLOW        8'h2A
// Pick-up timeout in ms and cycles at 100 MHz
`define PFS_PICK_TMO_MS     32'h000005DC
`define PFS_CLK_KHZ         32'h000186A0
`define PFS_PICK_TMO_CYC    (`PFS_PICK_TMO_MS * `PFS_CLK_KHZ)
// Cycles per length tick (1 ms)
`define PFS_MS_CYC          (`PFS_CLK_KHZ)
// Length tolerance in mm
`define PFS_LEN_TOL_MM      16'h0005
// Micrometres in one millimetre of sheet travel
`define PFS_UM_PER_MM       32'h000003E8
`define PFS_MAX_TRIES       2'h2
`endif

// file: verilog/pfs_paper_feed.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"
module pfs_paper_feed
  import pfs_pkg::*;
#(
  parameter int PICK_TMO_CYC = `PFS_PICK_TMO_CYC,
  parameter int MS_CYC       = `PFS_MS_CYC
) (
  input  wire logic        i_clk_sys,             // 100 MHz clock
  input  wire logic        i_sys_rst,             // Sync reset, high
  input  wire logic        i_print_req,           // Print request pulse
  input  wire pfs_media_t  i_media_type,          // Requested media
  input  wire logic [15:0] i_req_len_mm,          // Requested length
  input  wire logic        i_image_start,         // Image sync pulse
  input  wire logic        i_err_clear,           // Clear errors pulse
  input  wire logic        i_job_cancel,          // Cancel job pulse
  input  wire logic        i_tray_empty_sensor,   // High when blocked
  input  wire logic        i_registration_sensor, // High when blocked
  input  wire logic        i_transparency_sensor, // High when film
  output logic [7:0]       o_main_motor_speed,    // Speed setting
  output logic             o_main_motor_run,      // Motor on
  output logic             o_pickup_solenoid,     // Pick-up drive
  output logic             o_registration_solenoid, // Rollers drive
  output logic             o_busy,                // Sheet in progress
  output logic             o_tray_empty,          // Tray empty flag
  output logic             o_type_mismatch,       // Media mismatch
  output logic             o_size_error,          // Size mismatch
  output logic             o_misfeed,             // Retry also failed
  output logic             o_clean_trigger,       // Cleaning trigger pulse
  output logic [15:0]      o_meas_len_mm          // Last measured length
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PICK, ST_WAIT_IMG, ST_FEED, ST_HALT
  } pfs_state_t;

  typedef struct packed {
    pfs_state_t  state;
    logic [7:0]  speed;
    logic        film_req;
    logic [15:0] req_len;
    logic [1:0]  tries;
    logic [31:0] tmo;
    logic        seen_clear;
    logic [31:0] ms_div;
    logic [31:0] len_um;
    logic        reg_prev;
    logic        tray_empty;
    logic        mismatch;
    logic        size_err;
    logic        misfeed;
    logic        clean;
    logic [15:0] meas_len;
  } pfs_st_t;

  pfs_st_t     st_q, st_d;
  logic [2:0]  pins_s;
  logic        tray_blk, reg_blk, film_s;
  logic [15:0] len_mm;
  logic [15:0] diff;

  // All three sensors are asynchronous to the engine clock
  pfs_sync #(.W(3)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async  ({i_tray_empty_sensor, i_registration_sensor, i_transparency_sensor}),
    .o_sync   (pins_s)
  );
  assign {tray_blk, reg_blk, film_s} = pins_s;

  // Exact divide: a power-of-two shift would shrink a long sheet past the tolerance
  assign len_mm = 16'(st_q.len_um / `PFS_UM_PER_MM);
  assign diff   = (len_mm > st_q.req_len) ? len_mm - st_q.req_len : st_q.req_len - len_mm;

  always_comb begin
    st_d          = st_q;
    st_d.clean    = 1'b0;
    st_d.reg_prev = reg_blk;
    st_d.tray_empty = tray_blk;
    if (i_err_clear || i_job_cancel) begin
      st_d.size_err = 1'b0;
      st_d.mismatch = 1'b0;
      st_d.misfeed  = 1'b0;
    end
    unique case (st_q.state)
      ST_IDLE: begin
        if (i_print_req && !tray_blk && !st_q.size_err && !st_q.mismatch) begin
          unique case (i_media_type)
            PFS_MEDIA_PLAIN, PFS_MEDIA_LETTERHEAD: st_d.speed = `PFS_SPD_FAST;
            PFS_MEDIA_FILM, PFS_MEDIA_ENVELOPE:    st_d.speed = `PFS_SPD_SLOW;
            PFS_MEDIA_THICK, PFS_MEDIA_POSTCARD,
            PFS_MEDIA_LABEL, PFS_MEDIA_GLOSSY:     st_d.speed = `PFS_SPD_MID;
          endcase
          st_d.film_req   = (i_media_type == PFS_MEDIA_FILM);
          st_d.req_len    = i_req_len_mm;
          st_d.tries      = 2'h1;
          st_d.tmo        = '0;
          st_d.seen_clear = 1'b0;
          st_d.state      = ST_PICK;
        end else if (i_print_req && tray_blk) begin
          st_d.clean = 1'b1;
        end
      end
      ST_PICK: begin
        st_d.tmo = st_q.tmo + 32'h1;
        if (!reg_blk) st_d.seen_clear = 1'b1;
        if (st_q.seen_clear && reg_blk && !st_q.reg_prev) begin
          st_d.mismatch = (film_s != st_q.film_req);
          st_d.state    = (film_s != st_q.film_req) ? ST_HALT : ST_WAIT_IMG;
        end else if (st_q.tmo >= PICK_TMO_CYC - 1) begin
          // A retry leaves the solenoid energised so the clutch stays engaged
          if (st_q.tries < `PFS_MAX_TRIES) begin
            st_d.tries      = st_q.tries + 2'h1;
            st_d.tmo        = '0;
            st_d.seen_clear = 1'b0;
          end else begin
            st_d.misfeed = 1'b1;
            st_d.state   = ST_HALT;
          end
        end
      end
      ST_WAIT_IMG: begin
        // Motor rests so the held sheet cannot buckle at the roller
        st_d.ms_div = '0;
        st_d.len_um = '0;
        if (i_image_start) st_d.state = ST_FEED;
      end
      ST_FEED: begin
        if (st_q.ms_div >= MS_CYC - 1) begin
          st_d.ms_div = '0;
          st_d.len_um = st_q.len_um + {24'h0, st_q.speed};
        end else begin
          st_d.ms_div = st_q.ms_div + 32'h1;
        end
        if (!reg_blk) begin
          st_d.meas_len = len_mm;
          st_d.state    = ST_IDLE;
          if (diff > `PFS_LEN_TOL_MM) begin
            st_d.size_err = 1'b1;
            st_d.clean    = 1'b1;
          end
        end
      end
      ST_HALT: begin
        if (i_err_clear || i_job_cancel) st_d.state = ST_IDLE;
      end
      default: st_d.state = ST_IDLE;
    endcase
    if (tray_blk && !st_q.tray_empty && st_q.state != ST_IDLE)
      st_d.clean = 1'b1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q       <= '0;
      st_q.state <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_main_motor_speed      = st_q.speed;
  assign o_main_motor_run        = (st_q.state == ST_PICK) || (st_q.state == ST_FEED);
  assign o_pickup_solenoid       = (st_q.state == ST_PICK);
  assign o_registration_solenoid = (st_q.state == ST_FEED);
  assign o_busy                  = (st_q.state != ST_IDLE);
  assign o_tray_empty            = st_q.tray_empty;
  assign o_type_mismatch         = st_q.mismatch;
  assign o_size_error            = st_q.size_err;
  assign o_misfeed               = st_q.misfeed;
  assign o_clean_trigger         = st_q.clean;
  assign o_meas_len_mm           = st_q.meas_len;

  sequence feed_go_s;
    st_q.state == ST_WAIT_IMG && i_image_start;
  endsequence
  size_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_q.size_err && !i_err_clear && !i_job_cancel |=> !o_pickup_solenoid || $past(o_pickup_solenoid))
    else $error("Pick-up started while size error pending");
  feed_start_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    feed_go_s |=> o_registration_solenoid)
    else $error("Rollers did not restart on image start");
  pick_sol_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_pickup_solenoid |-> o_main_motor_run && !o_registration_solenoid)
    else $error("Pick-up solenoid without motor");
  speed_sel_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_q.state == ST_IDLE && i_print_req && !tray_blk && !st_q.size_err && !st_q.mismatch
    && i_media_type == PFS_MEDIA_FILM |=> o_main_motor_speed == `PFS_SPD_SLOW)
    else $error("Wrong feed speed for film");

  sequence sheet_out_s;
    $fell(o_registration_solenoid) && !o_busy;
  endsequence
  roll_lock_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_registration_solenoid |-> o_main_motor_run && !o_pickup_solenoid)
    else $error("Registration rollers driven without motor");
  tray_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_sys_rst, 1) && !$past(i_sys_rst, 2) && !$past(i_sys_rst, 3)
    |-> o_tray_empty == $past(i_tray_empty_sensor, 3))
    else $error("Tray empty flag does not follow sensor");
  type_halt_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_type_mismatch |-> !o_pickup_solenoid && !o_registration_solenoid)
    else $error("Feed continued with media mismatch");
  misfeed_halt_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_misfeed |-> !o_pickup_solenoid && !o_registration_solenoid)
    else $error("Feed continued after failed retry");
  size_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_size_error) |-> sheet_out_s)
    else $error("Size error raised away from sheet exit");
  clean_size_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_size_error) |-> o_clean_trigger)
    else $error("No cleaning trigger on size error");
endmodule : pfs_paper_feed

// file: verilog/pfs_pkg.sv
package pfs_pkg;
  typedef enum logic [2:0] {
    PFS_MEDIA_PLAIN, PFS_MEDIA_LETTERHEAD, PFS_MEDIA_THICK, PFS_MEDIA_POSTCARD,
    PFS_MEDIA_LABEL, PFS_MEDIA_GLOSSY, PFS_MEDIA_FILM, PFS_MEDIA_ENVELOPE
  } pfs_media_t;
endpackage : pfs_pkg

// file: verilog/pfs_sync.sv
`timescale 1ns/1ps
module pfs_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_sys_rst, // Synchronous reset
  input  wire logic [W-1:0] i_async,   // Pin levels
  output logic      [W-1:0] o_sync     // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pfs_sync_st_t;
  pfs_sync_st_t st_q, st_d;
  always_comb begin
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) st_q <= '0;
    else st_q <= st_d;
  end
  assign o_sync = st_q.s2;
endmodule : pfs_sync
